// *** logic/sbs_buf2.sv ***
// small flip-flop fifo with valid and ready on both sides
// assumes one clock and an async active-high reset
`timescale 1ns/100ps
module sbs_buf2
  import sbs_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int DP = BUF_DEPTH
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // fill side
  input  wire logic          in_valid_in,
  output logic               in_ready_out,
  input  wire logic [DW-1:0] in_data_in,
  // drain side
  output logic               out_valid_out,
  input  wire logic          out_ready_in,
  output logic [DW-1:0]      out_data_out,
  // occupancy
  output logic [2:0]         count_out
);
  localparam int PW = (DP > 1) ? $clog2(DP) : 1;

  logic [DW-1:0] mem_reg [DP];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [2:0]    cnt_reg,    cnt_next;
  logic          push, pop;

  // handshakes and pointer advance
  always_comb begin
    push        = in_valid_in && in_ready_out;
    pop         = out_valid_out && out_ready_in;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next    = cnt_reg;
    if (push) begin
      wr_ptr_next = (int'(wr_ptr_reg) == DP - 1) ? '0 : PW'(wr_ptr_reg + 1'b1);
    end
    if (pop) begin
      rd_ptr_next = (int'(rd_ptr_reg) == DP - 1) ? '0 : PW'(rd_ptr_reg + 1'b1);
    end
    if (push && !pop) begin
      cnt_next = 3'(cnt_reg + 3'h1);
    end else if (pop && !push) begin
      cnt_next = 3'(cnt_reg - 3'h1);
    end
  end

  // pointer and count registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= 3'h0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  // honest full and empty
  assign in_ready_out  = (int'(cnt_reg) < DP);
  assign out_valid_out = (cnt_reg != 3'h0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign count_out     = cnt_reg;

endmodule

// *** logic/sbs_ctrl.sv ***
// memory controller end: turns user requests into sram pin cycles
// assumes the device shares clk_in and samples pins on the same edge
`timescale 1ns/100ps
module sbs_ctrl
  import sbs_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // requests
  input  wire logic              req_valid_in,
  output logic                   req_ready_out,
  input  wire logic              req_write_in,
  input  wire logic              req_step_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_data_in,
  input  wire logic [LANES-1:0]  req_lane_write_n_in,
  // static configuration
  input  wire logic              cfg_flow_in,
  input  wire logic              cfg_interleave_in,
  input  wire logic              sleep_in,
  // read return
  output logic                   rd_valid_out,
  input  wire logic              rd_ready_in,
  output logic [DATA_W-1:0]      rd_data_out,
  // sram pins
  sbs_if.ctl                     bus
);
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              adv_reg, adv_next, we_n_reg, we_n_next, cs_n_reg, cs_n_next;
  logic [LANES-1:0]  be_n_reg, be_n_next;
  logic              flow_n_reg, flow_n_next, lbo_n_reg, lbo_n_next, zz_reg, zz_next;
  logic              last_wr_reg, last_wr_next;
  logic              r1_reg, r1_next, r2_reg, r2_next, r3_reg, r3_next;
  logic              w1_reg, w1_next, w2_reg, w2_next;
  logic [DATA_W-1:0] wd1_reg, wd1_next, wd2_reg, wd2_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic              oe_reg, oe_next;
  logic              flow, accept, is_wr, push, buf_ready;
  logic [2:0]        buf_cnt, used;

  // credits keep every read in flight a free buffer slot
  always_comb begin
    flow          = !flow_n_reg;
    used          = 3'({2'h0, r1_reg} + {2'h0, r2_reg} + {2'h0, r3_reg && !flow} + buf_cnt);
    req_ready_out = buf_ready && (used < RD_CREDITS);
    accept        = req_valid_in && req_ready_out;
    is_wr         = req_step_in ? last_wr_reg : req_write_in;
    push          = flow ? r2_reg : r3_reg;
  end

  // next pin values and data pipeline
  always_comb begin
    addr_next    = addr_reg;
    we_n_next    = we_n_reg;
    be_n_next    = be_n_reg;
    last_wr_next = last_wr_reg;
    adv_next     = 1'b0;               // load unless a step is issued
    cs_n_next    = 1'b1;               // idle cycles deselect
    r1_next      = 1'b0;
    w1_next      = 1'b0;
    wd1_next     = wd1_reg;
    if (accept) begin
      adv_next     = req_step_in;
      cs_n_next    = 1'b0;
      addr_next    = req_addr_in;
      we_n_next    = !is_wr;
      be_n_next    = req_lane_write_n_in;
      last_wr_next = is_wr;
      r1_next      = !is_wr;
      w1_next      = is_wr;
      wd1_next     = req_data_in;
    end
    r2_next     = r1_reg;
    r3_next     = r2_reg;
    w2_next     = w1_reg;
    wd2_next    = wd1_reg;
    oe_next     = flow ? w1_reg : w2_reg;
    dq_next     = flow ? wd1_reg : wd2_reg;
    flow_n_next = !cfg_flow_in;
    lbo_n_next  = cfg_interleave_in;
    zz_next     = sleep_in;
  end

  // pin and pipeline registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_reg <= ADDR_RST;       adv_reg     <= 1'b0;
      we_n_reg <= 1'b1;           cs_n_reg    <= 1'b1;
      be_n_reg <= LANES_OFF_N;    last_wr_reg <= 1'b0;
      flow_n_reg <= 1'b1;         lbo_n_reg   <= 1'b0;
      zz_reg   <= 1'b0;
      r1_reg   <= 1'b0;           r2_reg      <= 1'b0;
      r3_reg   <= 1'b0;           w1_reg      <= 1'b0;
      w2_reg   <= 1'b0;           oe_reg      <= 1'b0;
      wd1_reg  <= DATA_RST;       wd2_reg     <= DATA_RST;
      dq_reg   <= DATA_RST;
    end else begin
      addr_reg <= addr_next;      adv_reg     <= adv_next;
      we_n_reg <= we_n_next;      cs_n_reg    <= cs_n_next;
      be_n_reg <= be_n_next;      last_wr_reg <= last_wr_next;
      flow_n_reg <= flow_n_next;  lbo_n_reg   <= lbo_n_next;
      zz_reg   <= zz_next;
      r1_reg   <= r1_next;        r2_reg      <= r2_next;
      r3_reg   <= r3_next;        w1_reg      <= w1_next;
      w2_reg   <= w2_next;        oe_reg      <= oe_next;
      wd1_reg  <= wd1_next;       wd2_reg     <= wd2_next;
      dq_reg   <= dq_next;
    end
  end

  // read words land here so a stalled reader loses none
  sbs_buf2 #(.DW(DATA_W), .DP(BUF_DEPTH)) u_rd_buf (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_ready_out  (buf_ready),
    .in_data_in    (bus.dq),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out),
    .count_out     (buf_cnt)
  );

  // pins
  assign bus.addr                  = addr_reg;
  assign bus.clk_gate_n            = 1'b0;
  assign bus.counter_load_or_step  = adv_reg;
  assign bus.store_select_n        = we_n_reg;
  assign bus.byte_lane_write_n     = be_n_reg;
  assign bus.chip_sel_low_1        = cs_n_reg;
  assign bus.chip_sel_high         = 1'b1;
  assign bus.chip_sel_low_3        = 1'b0;
  assign bus.output_drive_allow_n  = 1'b0;
  assign bus.sleep_request         = zz_reg;
  assign bus.flow_mode_select_n    = flow_n_reg;
  assign bus.linear_order_select_n = lbo_n_reg;
  assign bus.ctl_dq_out            = dq_reg;
  assign bus.ctl_dq_oe             = oe_reg;

endmodule

// *** logic/sbs_sram_dev.sv ***
// device end: late-write burst sram with byte lanes in flip-flops
// assumes the controller drives pins from flops on the same clk_in
`timescale 1ns/100ps
module sbs_sram_dev
  import sbs_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // status
  output logic      sleep_active_out,
  // sram pins
  sbs_if.dev        bus
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_reg [DEPTH];
  sbs_op_e           op_reg,    op_next;     // command stage
  logic [ADDR_W-1:0] base_reg,  base_next;
  logic [1:0]        start_reg, start_next;
  logic [1:0]        cnt_reg,   cnt_next;
  logic [LANES-1:0]  be_n_reg,  be_n_next;
  sbs_op_e           s2_op_reg, s2_op_next;  // second stage
  logic [ADDR_W-1:0] s2_addr_reg, s2_addr_next;
  logic [LANES-1:0]  s2_be_n_reg, s2_be_n_next;
  logic [DATA_W-1:0] dout_reg,  dout_next;
  logic              oe_reg,    oe_next;
  logic              zz_s1_reg, zz_s2_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic              run, selected, flow, interleave;
  logic [ADDR_W-1:0] cur_addr, new_addr;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_word;

  // address of an access from base, start bits and count
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [ADDR_W-1:0] base,
                                                 input logic [1:0]        start,
                                                 input logic [1:0]        cnt,
                                                 input logic              ilv);
    eff_addr = {base[ADDR_W-1:2], sbs_burst_bits(start, cnt, ilv)};
  endfunction

  // mode pins and run gate
  always_comb begin
    run        = !bus.clk_gate_n && !zz_s2_reg;
    selected   = !bus.chip_sel_low_1 && bus.chip_sel_high
                 && !bus.chip_sel_low_3;
    flow       = !bus.flow_mode_select_n;
    interleave = bus.linear_order_select_n;
    cur_addr   = eff_addr(base_reg, start_reg, cnt_reg, interleave);
  end

  // command stage: load on low, step on high
  always_comb begin
    op_next    = op_reg;
    base_next  = base_reg;
    start_next = start_reg;
    cnt_next   = cnt_reg;
    be_n_next  = be_n_reg;
    if (run) begin
      be_n_next = bus.byte_lane_write_n;
      if (!bus.counter_load_or_step) begin
        base_next  = bus.addr;
        start_next = bus.addr[1:0];
        cnt_next   = BURST_CNT_RST;
        if (!selected) begin
          op_next = SBS_OP_DESEL;
        end else if (bus.store_select_n) begin
          op_next = SBS_OP_READ;
        end else begin
          op_next = SBS_OP_WRITE;
        end
      end else begin
        cnt_next = 2'(cnt_reg + 2'h1);
      end
    end
    new_addr = eff_addr(base_next, start_next, cnt_next, interleave);
  end

  // second stage, output register and drive enable
  always_comb begin
    s2_op_next   = s2_op_reg;
    s2_addr_next = s2_addr_reg;
    s2_be_n_next = s2_be_n_reg;
    dout_next    = dout_reg;
    oe_next      = oe_reg;
    if (zz_s2_reg) begin
      oe_next = 1'b0;
    end else if (run) begin
      s2_op_next   = op_reg;
      s2_addr_next = cur_addr;
      s2_be_n_next = be_n_reg;
      if (flow) begin
        dout_next = mem_reg[new_addr];
        oe_next   = (op_next == SBS_OP_READ);
      end else begin
        dout_next = mem_reg[cur_addr];
        oe_next   = (op_reg == SBS_OP_READ);
      end
    end
  end

  // late write: one edge after command in flow, two in pipelined
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = cur_addr;
    wr_word = DATA_RST;
    if (run) begin
      if (flow && op_reg == SBS_OP_WRITE) begin
        wr_en   = 1'b1;
        wr_idx  = cur_addr;
        wr_word = sbs_lane_merge(mem_reg[cur_addr], bus.dq, be_n_reg);
      end else if (!flow && s2_op_reg == SBS_OP_WRITE) begin
        wr_en   = 1'b1;
        wr_idx  = s2_addr_reg;
        wr_word = sbs_lane_merge(mem_reg[s2_addr_reg], bus.dq, s2_be_n_reg);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // control and pipeline state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_reg      <= SBS_OP_DESEL;
      base_reg    <= ADDR_RST;
      start_reg   <= BURST_CNT_RST;
      cnt_reg     <= BURST_CNT_RST;
      be_n_reg    <= LANES_OFF_N;
      s2_op_reg   <= SBS_OP_DESEL;
      s2_addr_reg <= ADDR_RST;
      s2_be_n_reg <= LANES_OFF_N;
      dout_reg    <= DATA_RST;
      oe_reg      <= 1'b0;
    end else begin
      op_reg      <= op_next;
      base_reg    <= base_next;
      start_reg   <= start_next;
      cnt_reg     <= cnt_next;
      be_n_reg    <= be_n_next;
      s2_op_reg   <= s2_op_next;
      s2_addr_reg <= s2_addr_next;
      s2_be_n_reg <= s2_be_n_next;
      dout_reg    <= dout_next;
      oe_reg      <= oe_next;
    end
  end

  // sleep request is asynchronous: two flops give the two-cycle entry
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      zz_s1_reg <= 1'b0;
      zz_s2_reg <= 1'b0;
    end else begin
      zz_s1_reg <= bus.sleep_request;
      zz_s2_reg <= zz_s1_reg;
    end
  end

  // array, written on the edge itself with no external pulse
  always_ff @(posedge clk_in) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_word;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // drive allow overrides the registered enable without the clock
  assign bus.dev_dq_out  = dout_reg;
  assign bus.dev_dq_oe   = oe_reg && !bus.output_drive_allow_n;
  assign sleep_active_out = zz_s2_reg;

endmodule

// *** pkg/sbs_if.sv ***
// pins between the memory controller and the burst sram
// assumes the testbench joins one controller end and one device end
`timescale 1ns/100ps
interface sbs_if;
  import sbs_pkg::*;

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr;                   // word address, low two bits start a burst
  logic              clk_gate_n;             // high: edges ignored
  logic              counter_load_or_step;   // low load, high step
  logic              store_select_n;         // low write, high read
  logic [LANES-1:0]  byte_lane_write_n;      // per-lane write strobes
  logic              chip_sel_low_1;
  logic              chip_sel_high;
  logic              chip_sel_low_3;
  logic              output_drive_allow_n;   // high: device drivers off
  logic              sleep_request;
  logic              flow_mode_select_n;     // low flow-through
  logic              linear_order_select_n;  // low linear, high interleaved
  logic [DATA_W-1:0] ctl_dq_out;
  logic              ctl_dq_oe;
  logic [DATA_W-1:0] dev_dq_out;
  logic              dev_dq_oe;
  logic [DATA_W-1:0] dq;                     // resolved data bus level

  // wire level from the two drivers, undriven reads as zero
  assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : DATA_RST);

  // ----------------------------------------------------------------
  // ends
  // ----------------------------------------------------------------
  modport dev (
    input  addr, clk_gate_n, counter_load_or_step, store_select_n,
    input  byte_lane_write_n, chip_sel_low_1, chip_sel_high, chip_sel_low_3,
    input  output_drive_allow_n, sleep_request, flow_mode_select_n,
    input  linear_order_select_n, dq,
    output dev_dq_out, dev_dq_oe
  );

  modport ctl (
    output addr, clk_gate_n, counter_load_or_step, store_select_n,
    output byte_lane_write_n, chip_sel_low_1, chip_sel_high, chip_sel_low_3,
    output output_drive_allow_n, sleep_request, flow_mode_select_n,
    output linear_order_select_n, ctl_dq_out, ctl_dq_oe,
    input  dq
  );

endinterface

// *** pkg/sbs_pkg.sv ***
// shared constants, types and helpers for the burst sram port pair
// assumes both ends run on one rising-edge clock
package sbs_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 6;   // word address width of the array
  localparam int DEPTH     = 64;  // words held in the array
  localparam int LANES     = 4;   // byte lanes per word
  localparam int LANE_W    = 9;   // bits per byte lane
  localparam int DATA_W    = 36;  // LANES * LANE_W
  localparam int BUF_DEPTH = 2;   // read return buffer entries

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0]        BURST_CNT_RST = 2'h0;
  localparam logic [2:0]        RD_CREDITS    = 3'h2;  // reads + buffered words
  localparam logic [DATA_W-1:0] DATA_RST      = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST      = 6'h00;
  localparam logic [LANES-1:0]  LANES_OFF_N   = 4'hF;

  // ----------------------------------------------------------------
  // operation held by the device command stage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SBS_OP_DESEL,
    SBS_OP_READ,
    SBS_OP_WRITE
  } sbs_op_e;

  // low address bits for a burst step: linear adds, interleaved xors
  function automatic logic [1:0] sbs_burst_bits(input logic [1:0] start,
                                                input logic [1:0] cnt,
                                                input logic       interleave);
    sbs_burst_bits = interleave ? (start ^ cnt) : 2'(start + cnt);
  endfunction

  // replace only lanes whose active-low write strobe is low
  function automatic logic [DATA_W-1:0] sbs_lane_merge(input logic [DATA_W-1:0] old_w,
                                                       input logic [DATA_W-1:0] new_w,
                                                       input logic [LANES-1:0]  wr_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!wr_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    sbs_lane_merge = res;
  endfunction

endpackage

// *** tb/sbs_properties.sv ***
// pin-level checks between the controller end and the device end
// assumes one clock, async high reset, interface signals wired by name
`timescale 1ns/100ps
module sbs_properties (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // sram pins
  input wire logic clk_gate_n,
  input wire logic counter_load_or_step,
  input wire logic store_select_n,
  input wire logic chip_sel_low_1,
  input wire logic chip_sel_high,
  input wire logic chip_sel_low_3,
  input wire logic output_drive_allow_n,
  input wire logic sleep_request,
  input wire logic flow_mode_select_n,
  input wire logic linear_order_select_n,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe
);
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic run, sel, rd_ld, wr_ld, stp, flow;
  // command seen by the device at each edge
  assign run   = !clk_gate_n && !sleep_request;
  assign sel   = !chip_sel_low_1 && chip_sel_high && !chip_sel_low_3;
  assign rd_ld = run && sel && !counter_load_or_step && store_select_n && !output_drive_allow_n;
  assign wr_ld = run && sel && !counter_load_or_step && !store_select_n;
  assign stp   = run && counter_load_or_step;
  assign flow  = !flow_mode_select_n;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_rd_flow; rd_ld && flow |-> ##1 dev_dq_oe; endproperty
  a_rd_flow: assert property (p_rd_flow) else $error("flow read data not driven");
  property p_rd_pipe; rd_ld && !flow |-> ##2 dev_dq_oe; endproperty
  a_rd_pipe: assert property (p_rd_pipe) else $error("pipelined read data not driven");
  property p_wr_flow; wr_ld && flow |-> ##1 (ctl_dq_oe && !dev_dq_oe); endproperty
  a_wr_flow: assert property (p_wr_flow) else $error("flow write data cycle wrong");
  property p_wr_pipe; wr_ld && !flow |-> ##2 (ctl_dq_oe && !dev_dq_oe); endproperty
  a_wr_pipe: assert property (p_wr_pipe) else $error("pipelined write data cycle wrong");
  property p_excl; !(dev_dq_oe && ctl_dq_oe); endproperty
  a_excl: assert property (p_excl) else $error("both ends drive data");
  property p_desel; (run && !counter_load_or_step && !sel) [*2] |=> !dev_dq_oe; endproperty
  a_desel: assert property (p_desel) else $error("device drives while deselected");
  property p_step_wr; wr_ld && flow ##1 stp |-> ##1 ctl_dq_oe; endproperty
  a_step_wr: assert property (p_step_wr) else $error("write step lost its data");
  property p_step_rd; rd_ld && flow ##1 stp |-> ##1 dev_dq_oe; endproperty
  a_step_rd: assert property (p_step_rd) else $error("read step not driven");
  property p_sleep; sleep_request [*3] |=> !dev_dq_oe; endproperty
  a_sleep: assert property (p_sleep) else $error("device drives while asleep");
  // main traffic kinds seen
  c_rd_pipe: cover property (rd_ld && !flow);
  c_wr_flow: cover property (wr_ld && flow);
  c_step_ilv: cover property (stp && linear_order_select_n);
endmodule

// *** tb/tb.sv ***
// self-checking bench: controller and device joined by the pin interface
// assumes 40 MHz clock and the hand-over latencies of both ends
`timescale 1ns/100ps
module tb;
  import sbs_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              req_valid_in, req_ready_out, req_write_in, req_step_in;
  logic              cfg_flow_in, cfg_interleave_in, sleep_in;
  logic              rd_valid_out, rd_ready_in;
  logic              sleep_active_out;
  logic [ADDR_W-1:0] req_addr_in;
  logic [DATA_W-1:0] req_data_in, rd_data_out;
  logic [LANES-1:0]  req_lane_write_n_in;
  logic [DATA_W-1:0] got[$];
  int                fails = 0;
  int                n_tests = 0;

  sbs_if bus ();
  sbs_ctrl i_sbs_ctrl (.clk_in, .rst_in, .req_valid_in, .req_ready_out, .req_write_in,
    .req_step_in, .req_addr_in, .req_data_in, .req_lane_write_n_in, .cfg_flow_in,
    .cfg_interleave_in, .sleep_in, .rd_valid_out, .rd_ready_in, .rd_data_out, .bus(bus));
  sbs_sram_dev i_sbs_sram_dev (.clk_in, .rst_in, .sleep_active_out, .bus(bus));
  sbs_properties i_props (.clk_in, .rst_in, .clk_gate_n(bus.clk_gate_n),
    .counter_load_or_step(bus.counter_load_or_step), .store_select_n(bus.store_select_n),
    .chip_sel_low_1(bus.chip_sel_low_1), .chip_sel_high(bus.chip_sel_high),
    .chip_sel_low_3(bus.chip_sel_low_3), .output_drive_allow_n(bus.output_drive_allow_n),
    .sleep_request(bus.sleep_request), .flow_mode_select_n(bus.flow_mode_select_n),
    .linear_order_select_n(bus.linear_order_select_n), .ctl_dq_oe(bus.ctl_dq_oe),
    .dev_dq_oe(bus.dev_dq_oe));

  // clock
  always #12.5 clk_in = ~clk_in;
  // read words popped from the return buffer
  always @(posedge clk_in)
    if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1) got.push_back(rd_data_out);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo(input string what);
    fails++;
    $display("BAD %s expected done seen timeout", what);
    print_verdict();
  endtask
  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hold one request until taken, valid left high for back to back use
  task automatic req(input logic w, input logic s, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [LANES-1:0] ln);
    int n = 0;
    req_valid_in = 1'b1;
    req_write_in = w;
    req_step_in = s;
    req_addr_in = a;
    req_data_in = d;
    req_lane_write_n_in = ln;
    while (req_ready_out !== 1'b1 && n < 50) begin
      @(posedge clk_in) #2;
      n++;
    end
    if (req_ready_out !== 1'b1) tmo("req_ready_out");
    @(posedge clk_in) #2;
  endtask
  task automatic idle(input int n);
    req_valid_in = 1'b0;
    repeat (n) @(posedge clk_in) #2;
  endtask
  task automatic get(input string what, input logic [DATA_W-1:0] exp);
    int n = 0;
    while (got.size() == 0 && n < 50) begin
      @(posedge clk_in) #2;
      n++;
    end
    if (got.size() == 0) tmo(what);
    else chk(what, exp, got.pop_front());
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // pipelined: full write, two-lane write, no-lane write, read back
  task automatic t_lanes();
    req(1'b1, 1'b0, 6'h05, 36'hF_FFFF_FFFF, 4'h0);
    req(1'b1, 1'b0, 6'h05, 36'h0_0000_0000, 4'hA);
    req(1'b1, 1'b0, 6'h05, 36'h0_0000_0000, 4'hF);
    idle(4);
    req(1'b0, 1'b0, 6'h05, 36'h0_0000_0000, 4'hF);
    idle(1);
    get("lane_merge", 36'hF_F803_FE00);
    $display("t_lanes done");
  endtask
  // flow: read then write on the next edge, then read back
  task automatic t_flow();
    req(1'b0, 1'b0, 6'h05, 36'h0_0000_0000, 4'hF);
    req(1'b1, 1'b0, 6'h05, 36'h1_2345_6789, 4'h0);
    idle(4);
    req(1'b0, 1'b0, 6'h05, 36'h0_0000_0000, 4'hF);
    idle(1);
    get("read_before_write", 36'hF_F803_FE00);
    get("write_after_read", 36'h1_2345_6789);
    $display("t_flow done");
  endtask
  // interleaved write burst from 9, linear read burst from B wraps to 8
  task automatic t_burst();
    cfg_interleave_in = 1'b1;
    idle(3);
    for (int k = 0; k < 4; k++) req(1'b1, k != 0, 6'h09, 36'h0_0000_0010 + k, 4'h0);
    idle(3);
    cfg_interleave_in = 1'b0;
    idle(3);
    req(1'b0, 1'b0, 6'h0B, 36'h0_0000_0000, 4'hF);
    req(1'b0, 1'b1, 6'h0B, 36'h0_0000_0000, 4'hF);
    idle(2);
    get("burst_first", 36'h0_0000_0012);
    get("burst_wrap", 36'h0_0000_0011);
    $display("t_burst done");
  endtask
  // receiver stalls: two reads fill the buffer, a third is refused
  task automatic t_stall();
    rd_ready_in = 1'b0;
    req(1'b0, 1'b0, 6'h08, 36'h0_0000_0000, 4'hF);
    req(1'b0, 1'b0, 6'h09, 36'h0_0000_0000, 4'hF);
    repeat (6) begin
      @(posedge clk_in) #2;
      chk("req_ready_out", 36'h0, {35'h0, req_ready_out});
    end
    chk("rd_valid_out", 36'h1, {35'h0, rd_valid_out});
    req_valid_in = 1'b0;
    rd_ready_in = 1'b1;
    get("stall_first", 36'h0_0000_0011);
    get("stall_second", 36'h0_0000_0010);
    $display("t_stall done");
  endtask
  // sleep: status on the second synced edge, array kept across it
  task automatic t_sleep();
    sleep_in = 1'b1;
    idle(2);
    chk("sleep_early", 36'h0, {35'h0, sleep_active_out});
    idle(1);
    chk("sleep_active_out", 36'h1, {35'h0, sleep_active_out});
    sleep_in = 1'b0;
    idle(3);
    chk("sleep_wake", 36'h0, {35'h0, sleep_active_out});
    req(1'b0, 1'b0, 6'h05, 36'h0_0000_0000, 4'hF);
    idle(1);
    get("sleep_kept", 36'h1_2345_6789);
    $display("t_sleep done");
  endtask

  // main sequence
  initial begin
    {req_valid_in, req_write_in, req_step_in} = 3'h0;
    {cfg_flow_in, cfg_interleave_in, sleep_in} = 3'h0;
    req_addr_in = 6'h00;
    req_data_in = 36'h0_0000_0000;
    req_lane_write_n_in = 4'hF;
    rd_ready_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #2 rst_in = 1'b0;
    @(posedge clk_in) #2;
    t_lanes();
    cfg_flow_in = 1'b1;
    idle(3);
    t_flow();
    t_burst();
    t_stall();
    t_sleep();
    print_verdict();
  end
endmodule
